/* verilog/srm_pkg.sv */
// Shared constants, types and register map of the sample rate meter
package srm_pkg;

  // Main clock rate and measurement reference
  localparam int unsigned CLK_HZ          = 200000000;
  localparam int unsigned REF_HZ          = 24576000;
  localparam int unsigned WIN_FRAMES_DEF  = 64;

  // Accepted rate bands, in Hz
  localparam int unsigned F32_LO          = 31200;
  localparam int unsigned F32_HI          = 32800;
  localparam int unsigned F441_LO         = 43000;
  localparam int unsigned F441_HI         = 45200;
  localparam int unsigned F48_LO          = 46800;
  localparam int unsigned F48_HI          = 49200;

  // Timing figures and their cycle counts at CLK_HZ
  localparam int unsigned REF_LOSS_NS     = 1000;
  localparam int unsigned REF_LOSS_CYC    =
    (REF_LOSS_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned CLKCHG_NS       = 1000;
  localparam int unsigned CLKCHG_CYC      =
    (CLKCHG_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned CU_DELAY_BCK    = 17;
  localparam int unsigned BSTART_FRAMES   = 8;
  localparam int unsigned JUMP_TOL_CNT    = 1024;

  // Count carried in the result
  localparam int unsigned MEAS_CNT_W      = 16;

  // Rate codes, upper bit first
  typedef logic [1:0] srm_code_t;
  localparam srm_code_t CODE_LL           = 2'h0;
  localparam srm_code_t CODE_LH           = 2'h1;
  localparam srm_code_t CODE_HL           = 2'h2;
  localparam srm_code_t CODE_HH           = 2'h3;

  // Register byte offsets
  localparam logic [3:0] REG_STATUS       = 4'h0;
  localparam logic [3:0] REG_MASK         = 4'h4;
  localparam logic [3:0] REG_RESULT       = 4'h8;
  localparam logic [3:0] REG_CTRL         = 4'hc;

  // Status and mask layout
  localparam int unsigned EV_W            = 4;
  localparam int unsigned EV_DONE_BIT     = 0;
  localparam int unsigned EV_LOST_BIT     = 1;
  localparam int unsigned EV_UNLOCK_BIT   = 2;
  localparam int unsigned EV_BLOCK_BIT    = 3;
  localparam logic [3:0] MASK_RST         = 4'h0;

  // Control and result fields
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam logic       CTRL_EN_RST      = 1'b1;
  localparam int unsigned RES_CODE_LSB    = 0;
  localparam int unsigned RES_EVER_BIT    = 2;
  localparam int unsigned RES_ALIVE_BIT   = 3;
  localparam int unsigned RES_LOCK_BIT    = 4;
  localparam int unsigned RES_CNT_LSB     = 16;

  // Measurement sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_COUNT} srm_state_e;

  // Synchronised receiver pins
  typedef struct packed {
    logic ref_clk;
    logic lock;
    logic frame;
    logic bitclk;
    logic cbit;
    logic ubit;
    logic preb;
    logic sel;
  } srm_pins_s;

  // Held measurement result
  typedef struct packed {
    srm_code_t               code;
    logic [MEAS_CNT_W-1:0]   count;
  } srm_meas_s;

endpackage

/* verilog/srm_rate_meter.sv */
// Sample rate meter with status pins and an Avalon-MM register slave
`timescale 1ns/1ps

// Summary of operation
// - Abrupt jump between successive measurements is an error and reads unlocked.
// - Reference edges counted as timebase for the input rate.
// - No reference edges, so no measurement is started or finished.
// - Reference error shifts count and bands; no correction applied.
// - Rate code comes from measurement only, never channel-status rate bits.
// - Unlocked or out of all bands gives code high-low.
// - Reference never seen since reset holds code at low-low.
// - Reference stopped after running freezes the last code.
// - Reference returning restarts measurement and updates the code.
// - Measured count is kept until the next finished measurement or reset.
// - Bands: 31.2-32.8k high-high, 43-45.2k low-low, 46.8-49.2k low-high.
// - Reference optional; decode paths work without it.
// - Channel-status and user bits latched 17 bit clocks after frame edge.
// - Loop mode with receive error selects free-running oscillator.
// - No tracked-frequency hold once lock is lost.
// - Clock change flag is active high on system clock transitions.
module srm_rate_meter
  import srm_pkg::*;
#(
  parameter int unsigned WIN_FRAMES = WIN_FRAMES_DEF
)(
  // Clock, reset and enable
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CLK_EN_I,
  // Receiver side inputs, asynchronous
  input  wire logic        REF_CLOCK_INPUT_I,
  input  wire logic        PLL_LOCK_I,
  input  wire logic        FRAME_CLK_I,
  input  wire logic        BIT_CLK_I,
  input  wire logic        CS_BIT_I,
  input  wire logic        USER_BIT_I,
  input  wire logic        PREAMBLE_B_I,
  input  wire logic        CLOCK_SOURCE_SELECT_I,
  // Status pins
  output logic [1:0]       RATE_CODE_OUT_O,
  output logic             CLOCK_CHANGE_FLAG_O,
  output logic             BLOCK_START_PULSE_O,
  output logic             CS_OUT_O,
  output logic             USER_OUT_O,
  output logic             FREE_RUN_O,
  output logic             IRQ_O,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);

  // Band limits as reference counts over one window
  localparam longint unsigned MNUM = longint'(REF_HZ) * WIN_FRAMES;
  localparam logic [MEAS_CNT_W-1:0] C32_MIN  = MEAS_CNT_W'(MNUM / F32_HI);
  localparam logic [MEAS_CNT_W-1:0] C32_MAX  = MEAS_CNT_W'(MNUM / F32_LO);
  localparam logic [MEAS_CNT_W-1:0] C441_MIN = MEAS_CNT_W'(MNUM / F441_HI);
  localparam logic [MEAS_CNT_W-1:0] C441_MAX = MEAS_CNT_W'(MNUM / F441_LO);
  localparam logic [MEAS_CNT_W-1:0] C48_MIN  = MEAS_CNT_W'(MNUM / F48_HI);
  localparam logic [MEAS_CNT_W-1:0] C48_MAX  = MEAS_CNT_W'(MNUM / F48_LO);
  localparam logic [MEAS_CNT_W-1:0] JTOL     = MEAS_CNT_W'(JUMP_TOL_CNT);
  localparam logic [MEAS_CNT_W-1:0] CNT_SAT  = '1;
  localparam logic [7:0]  WIN_LAST  = 8'(WIN_FRAMES - 1);
  localparam logic [7:0]  LOSS_LOAD = 8'(REF_LOSS_CYC);
  localparam logic [7:0]  CHG_LOAD  = 8'(CLKCHG_CYC);
  localparam logic [4:0]  CU_LAST   = 5'(CU_DELAY_BCK - 1);
  localparam logic [3:0]  BS_LOAD   = 4'(BSTART_FRAMES);

  // Refuse windows the counters cannot hold
  if (WIN_FRAMES < 2 || WIN_FRAMES > 83)
    $error("WIN_FRAMES must lie between 2 and 83");

  // Band decode of one finished count
  function automatic srm_code_t classify(input logic [MEAS_CNT_W-1:0] c);
    srm_code_t r;
    r = CODE_HL;
    if (c >= C32_MIN && c <= C32_MAX)
      r = CODE_HH;
    else if (c >= C441_MIN && c <= C441_MAX)
      r = CODE_LL;
    else if (c >= C48_MIN && c <= C48_MAX)
      r = CODE_LH;
    return r;
  endfunction

  srm_pins_s             pins_in;
  srm_pins_s             sync1_q;
  srm_pins_s             sync2_q;
  srm_pins_s             prev_q;
  srm_state_e            st_q;
  srm_state_e            st_d;
  srm_meas_s             res_q;
  logic [7:0]            loss_cnt_q;
  logic                  ever_q;
  logic [7:0]            frm_cnt_q;
  logic [MEAS_CNT_W-1:0] ref_cnt_q;
  logic [MEAS_CNT_W-1:0] prev_cnt_q;
  logic                  prev_vld_q;
  logic                  jump_q;
  srm_code_t             code_d;
  logic [4:0]            bck_cnt_q;
  logic                  cu_arm_q;
  logic                  cs_q;
  logic                  us_q;
  logic [3:0]            blk_cnt_q;
  logic                  blk_q;
  logic [7:0]            chg_cnt_q;
  logic                  chg_q;
  logic                  free_q;
  logic [EV_W-1:0]       status_q;
  logic [EV_W-1:0]       mask_q;
  logic                  meas_en_q;
  logic                  ack_q;
  logic [31:0]           rdata_q;

  // Pins gathered so one synchroniser serves them all
  assign pins_in = '{ref_clk: REF_CLOCK_INPUT_I, lock: PLL_LOCK_I,
                     frame: FRAME_CLK_I, bitclk: BIT_CLK_I,
                     cbit: CS_BIT_I, ubit: USER_BIT_I,
                     preb: PREAMBLE_B_I, sel: CLOCK_SOURCE_SELECT_I};

  // Two-stage synchroniser, then one stage kept for edge finding
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end
    else if (CLK_EN_I)
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end

  // Edges of the synchronised pins
  wire ref_rise   = sync2_q.ref_clk & ~prev_q.ref_clk;
  wire frame_rise = sync2_q.frame & ~prev_q.frame;
  wire frame_edge = sync2_q.frame ^ prev_q.frame;
  wire bit_rise   = sync2_q.bitclk & ~prev_q.bitclk;
  wire preb_rise  = sync2_q.preb & ~prev_q.preb;
  wire sel_change = sync2_q.sel ^ prev_q.sel;
  wire lock_chg   = sync2_q.lock ^ prev_q.lock;
  wire lock_fall  = prev_q.lock & ~sync2_q.lock;

  // Reference presence: a grounded pin never reloads the watchdog
  wire ref_alive   = (loss_cnt_q != 8'h00);
  wire ref_lost_ev = (loss_cnt_q == 8'h01) & ~ref_rise;
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      loss_cnt_q <= 8'h00;
      ever_q     <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (ref_rise)
        loss_cnt_q <= LOSS_LOAD;
      else if (ref_alive)
        loss_cnt_q <= loss_cnt_q - 8'h01;
      if (ref_rise)
        ever_q <= 1'b1;
    end

  // Sequencer runs only with reference, lock and software enable
  wire run_ok = ref_alive & sync2_q.lock & meas_en_q;
  wire done   = (st_q == ST_COUNT) & frame_rise & (frm_cnt_q == WIN_LAST);

  // Next state; windows follow back to back while conditions hold
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (run_ok)
          st_d = ST_ALIGN;
      ST_ALIGN:
        if (!run_ok)
          st_d = ST_IDLE;
        else if (frame_rise)
          st_d = ST_COUNT;
      ST_COUNT:
        if (!run_ok)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  // Window counters; a partial window is thrown away, not reported
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      st_q      <= ST_IDLE;
      frm_cnt_q <= 8'h00;
      ref_cnt_q <= '0;
    end
    else if (CLK_EN_I)
    begin
      st_q <= st_d;
      if (st_d != ST_COUNT || st_q != ST_COUNT || done)
      begin
        frm_cnt_q <= 8'h00;
        ref_cnt_q <= '0;
      end
      else
      begin
        if (frame_rise)
          frm_cnt_q <= frm_cnt_q + 8'h01;
        if (ref_rise && ref_cnt_q != CNT_SAT)
          ref_cnt_q <= ref_cnt_q + 1'b1;
      end
    end

  // Jump check against the previous window
  wire [MEAS_CNT_W-1:0] diff = (ref_cnt_q > prev_cnt_q) ?
                               (ref_cnt_q - prev_cnt_q) :
                               (prev_cnt_q - ref_cnt_q);
  wire big_jump = prev_vld_q & (diff > JTOL);
  wire lock_eff = sync2_q.lock & ~jump_q;

  // Code selection; reference loss holds, which outranks unlock
  assign code_d = (!ever_q || !ref_alive) ? res_q.code :
                  (!lock_eff)             ? CODE_HL :
                  (!done)                 ? res_q.code :
                  (big_jump)              ? CODE_HL :
                  classify(ref_cnt_q);

  // Result and jump history
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      res_q      <= '{code: CODE_LL, count: '0};
      prev_cnt_q <= '0;
      prev_vld_q <= 1'b0;
      jump_q     <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      res_q.code <= code_d;
      if (!sync2_q.lock)
      begin
        prev_vld_q <= 1'b0;
        jump_q     <= 1'b0;
      end
      else if (done)
      begin
        res_q.count <= ref_cnt_q;
        prev_cnt_q  <= ref_cnt_q;
        prev_vld_q  <= 1'b1;
        jump_q      <= big_jump;
      end
    end

  // Channel-status and user bits taken at the chosen bit clock after edge
  wire cu_fire = cu_arm_q & bit_rise & ~frame_edge & (bck_cnt_q == CU_LAST);
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      bck_cnt_q <= 5'h00;
      cu_arm_q  <= 1'b0;
      cs_q      <= 1'b0;
      us_q      <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (frame_edge)
      begin
        bck_cnt_q <= 5'h00;
        cu_arm_q  <= 1'b1;
      end
      else if (cu_fire)
      begin
        cu_arm_q <= 1'b0;
        cs_q     <= sync2_q.cbit;
        us_q     <= sync2_q.ubit;
      end
      else if (cu_arm_q && bit_rise)
        bck_cnt_q <= bck_cnt_q + 5'h01;
    end

  // Block start held for a fixed number of frames
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      blk_cnt_q <= 4'h0;
      blk_q     <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (preb_rise)
        blk_cnt_q <= BS_LOAD;
      else if (frame_rise && blk_cnt_q != 4'h0)
        blk_cnt_q <= blk_cnt_q - 4'h1;
      blk_q <= preb_rise | (blk_cnt_q > 4'h1) |
               ((blk_cnt_q == 4'h1) & ~frame_rise);
    end

  // Clock change flag; in loop mode a lock change swaps the clock
  wire chg_load = sel_change | (~sync2_q.sel & lock_chg);
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      chg_cnt_q <= 8'h00;
      chg_q     <= 1'b0;
      free_q    <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (chg_load)
        chg_cnt_q <= CHG_LOAD;
      else if (chg_cnt_q != 8'h00)
        chg_cnt_q <= chg_cnt_q - 8'h01;
      chg_q  <= chg_load | (chg_cnt_q > 8'h01);
      // Free-run chosen, never a held frequency
      free_q <= ~sync2_q.sel & ~sync2_q.lock;
    end

  // Bus decode; one wait cycle on every access
  wire bus_req  = AVS_READ_I | AVS_WRITE_I;
  wire hit_stat = (AVS_ADDRESS_I == REG_STATUS);
  wire hit_mask = (AVS_ADDRESS_I == REG_MASK);
  wire hit_res  = (AVS_ADDRESS_I == REG_RESULT);
  wire hit_ctrl = (AVS_ADDRESS_I == REG_CTRL);
  wire wr_fire  = AVS_WRITE_I & ack_q;
  wire rd_clr   = AVS_READ_I & ack_q & hit_stat;
  wire [31:0] res_word = {res_q.count, 11'h000, lock_eff, ref_alive,
                          ever_q, res_q.code};
  wire [31:0] rd_word  = hit_stat ? {28'h0000000, status_q} :
                         hit_mask ? {28'h0000000, mask_q} :
                         hit_res  ? res_word :
                         hit_ctrl ? {31'h00000000, meas_en_q} :
                         32'h00000000;

  // Events; a set in the clearing cycle survives
  wire [EV_W-1:0] ev = {preb_rise, lock_fall | (done & big_jump),
                        ref_alive & ref_lost_ev, done};
  wire [EV_W-1:0] status_d = (status_q & ~(rd_clr ? rdata_q[EV_W-1:0]
                                                  : {EV_W{1'b0}})) | ev;

  // Register file; only bits captured in read data are cleared
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h00000000;
      status_q  <= '0;
      mask_q    <= MASK_RST;
      meas_en_q <= CTRL_EN_RST;
    end
    else if (CLK_EN_I)
    begin
      ack_q    <= bus_req & ~ack_q;
      status_q <= status_d;
      if (AVS_READ_I && !ack_q)
        rdata_q <= rd_word;
      if (wr_fire && hit_mask)
        mask_q <= AVS_WRITEDATA_I[EV_W-1:0];
      if (wr_fire && hit_ctrl)
        meas_en_q <= AVS_WRITEDATA_I[CTRL_EN_BIT];
    end

  // Outputs
  assign RATE_CODE_OUT_O     = res_q.code;
  assign CLOCK_CHANGE_FLAG_O = chg_q;
  assign BLOCK_START_PULSE_O = blk_q;
  assign CS_OUT_O            = cs_q;
  assign USER_OUT_O          = us_q;
  assign FREE_RUN_O          = free_q;
  assign IRQ_O               = |(status_q & mask_q);
  assign AVS_READDATA_O      = rdata_q;
  assign AVS_WAITREQUEST_O   = bus_req & ~ack_q;

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence seq_ref_gone;
    !ref_alive && CLK_EN_I;
  endsequence
  sequence seq_unlocked;
    ever_q && ref_alive && !lock_eff && CLK_EN_I;
  endsequence

  chk_never_seen_ll: assert property (
    !ever_q |-> RATE_CODE_OUT_O == CODE_LL)
    else $error("code left low-low before any reference");
  chk_unlock_gives_hl: assert property (
    seq_unlocked |=> RATE_CODE_OUT_O == CODE_HL)
    else $error("unlocked but code not high-low");
  chk_stop_freezes: assert property (
    seq_ref_gone |=> $stable(RATE_CODE_OUT_O))
    else $error("code changed with reference stopped");
  chk_noref_idle: assert property (
    seq_ref_gone |=> st_q == ST_IDLE && !done)
    else $error("measurement ran without reference");
  chk_window_len: assert property (
    (done && CLK_EN_I) |=> frm_cnt_q == 8'h00 && ref_cnt_q == '0)
    else $error("window counters not restarted after finish");
  chk_band_code: assert property (
    (done && lock_eff && !big_jump && ever_q && ref_alive && CLK_EN_I &&
     ref_cnt_q >= C48_MIN && ref_cnt_q <= C48_MAX)
    |=> RATE_CODE_OUT_O == CODE_LH)
    else $error("48k band not coded low-high");
  chk_jump_hl: assert property (
    (done && big_jump && ever_q && ref_alive && sync2_q.lock && CLK_EN_I)
    |=> RATE_CODE_OUT_O == CODE_HL ##0 jump_q)
    else $error("rate jump not reported");
  chk_cu_delay: assert property (
    (cu_fire && CLK_EN_I) |=> CS_OUT_O == $past(sync2_q.cbit) &&
                              USER_OUT_O == $past(sync2_q.ubit))
    else $error("bits latched at wrong bit clock");
  chk_free_run: assert property (
    (!sync2_q.sel && !sync2_q.lock && CLK_EN_I) |=> FREE_RUN_O)
    else $error("free run not selected on error");
  chk_clk_change: assert property (
    (sel_change && CLK_EN_I) |=> CLOCK_CHANGE_FLAG_O [*2])
    else $error("clock change flag not raised");
  chk_bus_wait: assert property (
    (bus_req && !ack_q && CLK_EN_I) |=> !AVS_WAITREQUEST_O || !bus_req)
    else $error("bus answer later than one wait cycle");

endmodule

/* verif/srm_rx_model.sv */
// Far-side receiver model: reference, frame and bit clocks
`timescale 1ns/1ps
module srm_rx_model (
  // Control from the bench
  input  wire logic        ref_en_i,
  input  wire logic [31:0] frame_half_ns_i,
  // Clocks into the meter
  output logic             ref_clk_o,
  output logic             frame_o,
  output logic             bit_o
);
  // Start levels
  initial
  begin
    ref_clk_o = 1'b0;
    frame_o   = 1'b0;
    bit_o     = 1'b0;
  end

  // Reference at 8 MHz; stands low while stopped, like a dead crystal
  always
  begin
    if (ref_en_i)
    begin
      #62.5 ref_clk_o = 1'b1;
      #62.5 ref_clk_o = 1'b0;
    end
    else
      @(posedge ref_en_i);
  end

  // 32 bit clocks per frame half; period follows the bench at once
  always
  begin
    repeat (32)
    begin
      #(frame_half_ns_i / 64.0) bit_o = 1'b1;
      #(frame_half_ns_i / 64.0) bit_o = 1'b0;
    end
    frame_o = ~frame_o;
  end
endmodule

/* verif/test_srm_rate_meter.sv */
// Self-checking bench of the sample rate meter
`timescale 1ns/1ps
`define CHK(nm, ex, sn) \
  begin \
    check_count++; \
    if ((sn) !== (ex)) \
    begin \
      miscompares++; \
      $display("wrong value %s exp %0h seen %0h", nm, ex, sn); \
    end \
  end
module test_srm_rate_meter;
  import srm_pkg::*;
  // Two frames a window keeps the slow measurement short
  localparam int WIN       = 2;
  localparam int SLOW_HALF = 31875;
  localparam int FAST_HALF = 4000;
  // Slow enough that the next count leaves the last past the jump limit
  localparam int JUMP_HALF = 38000;
  localparam int EXP_SLOW  = 2 * SLOW_HALF * WIN / 125;
  localparam int EXP_FAST  = 2 * FAST_HALF * WIN / 125;

  // Bench state and design inputs
  int          miscompares = 0;
  int          check_count = 0;
  int          half_ns     = FAST_HALF;
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic        en          = 1'b1;
  logic        ref_en      = 1'b0;
  logic        lock        = 1'b1;
  logic        cs          = 1'b0;
  logic        usr         = 1'b0;
  logic        pre         = 1'b0;
  logic        sel         = 1'b0;
  logic [3:0]  addr        = 4'h0;
  logic        rd          = 1'b0;
  logic        wr          = 1'b0;
  logic [31:0] wdata       = 32'h0;
  logic [31:0] d;
  wire         ref_in;
  wire         frame;
  wire         bitc;
  wire [1:0]   code;
  wire         chg;
  wire         bstart;
  wire         cs_out;
  wire         u_out;
  wire         free_run;
  wire         irq;
  wire         waitreq;
  wire [31:0]  rdata;

  // 200 MHz main clock
  always #2.5 clk = ~clk;

  srm_rx_model u_srm_rx_model (
    .ref_en_i(ref_en), .frame_half_ns_i(half_ns),
    .ref_clk_o(ref_in), .frame_o(frame), .bit_o(bitc)
  );

  srm_rate_meter #(.WIN_FRAMES(WIN)) u_srm_rate_meter (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .CLK_EN_I(en),
    .REF_CLOCK_INPUT_I(ref_in), .PLL_LOCK_I(lock),
    .FRAME_CLK_I(frame), .BIT_CLK_I(bitc),
    .CS_BIT_I(cs), .USER_BIT_I(usr), .PREAMBLE_B_I(pre),
    .CLOCK_SOURCE_SELECT_I(sel),
    .RATE_CODE_OUT_O(code), .CLOCK_CHANGE_FLAG_O(chg),
    .BLOCK_START_PULSE_O(bstart), .CS_OUT_O(cs_out),
    .USER_OUT_O(u_out), .FREE_RUN_O(free_run), .IRQ_O(irq),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq)
  );

  // Avalon cycle; waitrequest and data taken at the same edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= wd;
    // No cycle count assumed; only the watchdog ends a dead wait
    do
      @(posedge clk);
    while (waitreq !== 1'b0);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait, so a dead meter cannot stall the run
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // Reset values and register access
  task automatic t_reset;
    `CHK("code", CODE_LL, code)
    `CHK("bstart", 1'b0, bstart)
    bus(1'b0, REG_MASK, 32'h0);
    `CHK("mask", 32'h0, d)
    bus(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, d)
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, d)
    bus(1'b1, REG_MASK, 32'hf);
    bus(1'b0, REG_MASK, 32'h0);
    `CHK("mask rw", 32'hf, d)
    bus(1'b1, REG_MASK, 32'h0);
  endtask

  // No reference: decode paths live, code stays low-low
  task automatic t_no_ref;
    @(frame);
    @(posedge clk);
    cs  <= 1'b1;
    usr <= 1'b1;
    repeat (16) @(posedge bitc);
    wait_cyc(5);
    `CHK("cs early", 1'b0, cs_out)
    `CHK("user early", 1'b0, u_out)
    repeat (1) @(posedge bitc);
    wait_cyc(5);
    `CHK("cs late", 1'b1, cs_out)
    `CHK("user late", 1'b1, u_out)
    pre <= 1'b1;
    wait_cyc(10);
    `CHK("bstart on", 1'b1, bstart)
    pre <= 1'b0;
    repeat (7) @(posedge frame);
    wait_cyc(10);
    `CHK("bstart held", 1'b1, bstart)
    @(posedge frame);
    wait_cyc(10);
    `CHK("bstart off", 1'b0, bstart)
    `CHK("code", CODE_LL, code)
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("done", 1'b0, d[EV_DONE_BIT])
  endtask

  // Lock loss with the reference running forces high-low
  task automatic t_unlock;
    half_ns = SLOW_HALF;
    @(posedge clk);
    ref_en <= 1'b1;
    wait_cyc(40);
    lock <= 1'b0;
    wait_cyc(10);
    `CHK("code", CODE_HL, code)
    `CHK("free run", 1'b1, free_run)
    `CHK("clk chg", 1'b1, chg)
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("unlock ev", 1'b1, d[EV_UNLOCK_BIT])
    `CHK("irq masked", 1'b0, irq)
    bus(1'b0, REG_RESULT, 32'h0);
    `CHK("ever", 1'b1, d[RES_EVER_BIT])
  endtask

  // Full window at one ref count per 125 ns lands in the low-high band
  task automatic t_measure;
    int c;
    bus(1'b1, REG_MASK, 32'h1 << EV_DONE_BIT);
    lock <= 1'b1;
    wait_irq(45000);
    `CHK("irq", 1'b1, irq)
    `CHK("code", CODE_LH, code)
    bus(1'b0, REG_RESULT, 32'h0);
    c = d[31:16];
    `CHK("count", 1'b1, c >= EXP_SLOW - 2 && c <= EXP_SLOW + 2)
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("done ev", 1'b1, d[EV_DONE_BIT])
    wait_cyc(2);
    `CHK("irq clr", 1'b0, irq)
  endtask

  // Reference stops: code frozen even when lock drops
  task automatic t_freeze;
    @(posedge clk);
    ref_en <= 1'b0;
    wait_cyc(400);
    lock <= 1'b0;
    wait_cyc(20);
    `CHK("code", CODE_LH, code)
    bus(1'b0, REG_RESULT, 32'h0);
    `CHK("alive", 1'b0, d[RES_ALIVE_BIT])
  endtask

  // Reference returns: fresh result, out of every band
  task automatic t_resume;
    int c;
    half_ns = FAST_HALF;
    @(posedge clk);
    lock   <= 1'b1;
    ref_en <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0);
    wait_irq(20000);
    `CHK("irq", 1'b1, irq)
    `CHK("code", CODE_HL, code)
    bus(1'b0, REG_RESULT, 32'h0);
    c = d[31:16];
    `CHK("count", 1'b1, c >= EXP_FAST - 2 && c <= EXP_FAST + 2)
  endtask

  // Abrupt rate change between two locked windows reads as an error
  task automatic t_jump;
    bus(1'b0, REG_STATUS, 32'h0);
    half_ns = JUMP_HALF;
    wait_cyc(2);
    wait_irq(34000);
    `CHK("irq", 1'b1, irq)
    `CHK("code", CODE_HL, code)
    bus(1'b0, REG_RESULT, 32'h0);
    `CHK("lock eff", 1'b0, d[RES_LOCK_BIT])
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("jump ev", 1'b1, d[EV_UNLOCK_BIT])
  endtask

  // Source select change raises the change flag for a while
  task automatic t_select;
    `CHK("chg idle", 1'b0, chg)
    @(posedge clk);
    en  <= 1'b0;
    sel <= 1'b1;
    wait_cyc(10);
    `CHK("chg frozen", 1'b0, chg)
    en <= 1'b1;
    wait_cyc(10);
    `CHK("chg on", 1'b1, chg)
    wait_cyc(400);
    `CHK("chg off", 1'b0, chg)
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    wait_cyc(8);
    rst_b <= 1'b1;
    t_reset();
    t_no_ref();
    t_unlock();
    t_measure();
    t_freeze();
    t_resume();
    t_jump();
    t_select();
    results();
  end

  // Watchdog: about 98k cycles, past the expected run of about 88k
  initial
  begin
    #490000;
    miscompares++;
    results();
  end
endmodule
